// file: include/pmc_pkg.sv
// shared constants, field layout and helpers for the misc configuration bank
package pmc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int DLY_TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_FREQ_KHZ * DLY_TICK_US) / 1000;
  localparam int TICK_W = 15;
  localparam int DLY_W = 8;

  // switch-off delay codes and their length in ticks
  localparam logic [1:0] SWOFF_NONE = 2'h0;
  localparam logic [1:0] SWOFF_SHORT = 2'h1;
  localparam logic [1:0] SWOFF_MID = 2'h2;
  localparam logic [DLY_W-1:0] SWOFF_SHORT_MS = 8'h0A;
  localparam logic [DLY_W-1:0] SWOFF_MID_MS = 8'h32;
  localparam logic [DLY_W-1:0] SWOFF_LONG_MS = 8'hC8;

  // ---------------------------------------------------------------
  // addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] PAGE_ADDR_DEFAULT = 7'h12;
  localparam logic [6:0] PAGE_ADDR_ALT = 7'h13;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  typedef struct packed {
    logic host_if_spi;
    logic page_address_select;
    logic auto_stay_on_enable;
    logic [1:0] switch_off_delay;
    logic irq_buffer_select;
    logic watchdog_sleep_hold;
    logic power_off_pin_fast_off;
    logic thermal_trip_fast_off;
    logic secondary_event_mask;
    logic irq_polarity_high;
    logic sync_clock_output_select;
  } pmc_cfg_s;

  localparam pmc_cfg_s CFG_RESET = '{
    host_if_spi: 1'h0,
    page_address_select: 1'h0,
    auto_stay_on_enable: 1'h0,
    switch_off_delay: SWOFF_NONE,
    irq_buffer_select: 1'h0,
    watchdog_sleep_hold: 1'h0,
    power_off_pin_fast_off: 1'h0,
    thermal_trip_fast_off: 1'h0,
    secondary_event_mask: 1'h1,
    irq_polarity_high: 1'h0,
    sync_clock_output_select: 1'h0
  };
  localparam logic STAY_ON_RESET = 1'h0;

  typedef enum logic [3:0] {
    FLD_HOST_IF = 4'h0,
    FLD_PAGE_ADDR = 4'h1,
    FLD_AUTO_STAY_ON = 4'h2,
    FLD_OFF_DELAY = 4'h3,
    FLD_IRQ_BUF = 4'h4,
    FLD_WDT_HOLD = 4'h5,
    FLD_PIN_FAST_OFF = 4'h6,
    FLD_THERM_FAST_OFF = 4'h7,
    FLD_EVT_MASK = 4'h8,
    FLD_IRQ_POL = 4'h9,
    FLD_SYNC_SEL = 4'hA,
    FLD_STAY_ON = 4'hB
  } pmc_field_e;

  // shutdown requests leaving the block, one-cycle pulses
  typedef struct packed {
    logic fast_off;
    logic seq_shutdown;
  } pmc_shutdown_s;

  function automatic logic [DLY_W-1:0] swoff_delay_ticks(input logic [1:0] code);
    logic [DLY_W-1:0] r;
    case (code)
      SWOFF_NONE: r = '0;
      SWOFF_SHORT: r = SWOFF_SHORT_MS;
      SWOFF_MID: r = SWOFF_MID_MS;
      default: r = SWOFF_LONG_MS;
    endcase
    return r;
  endfunction

endpackage

// file: logic/pmc_misc_config_bank.sv
// miscellaneous configuration bank of the power-management controller
//
// What this block does
// - zero in host-interface bit selects I2C
// - page address is 0x12 when select zero
// - auto option sets stay-on after startup sequence
// - switch-off waits programmed delay in ACTIVE
// - hold bit zero keeps watchdog running in sleep
// - pin fast-off zero gives sequenced shutdown
// - thermal fast-off zero gives sequenced shutdown
// - mask bit one blocks FSD interrupt source
// - polarity zero drives interrupt low when pending, with buffer bit zero only
// - sync output select zero picks converter clock
// - buffer bit zero gives standard interrupt driver
`timescale 1ns/1ns
module pmc_misc_config_bank #(
  parameter int P_TICK_CYCLES = pmc_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cfg_wr,
  input wire pmc_pkg::pmc_field_e i_cfg_sel,
  input wire logic [1:0] i_cfg_val,
  output pmc_pkg::pmc_cfg_s o_cfg,
  output logic o_stay_on,
  output logic o_host_if_spi,
  output logic [6:0] o_page_addr,
  input wire logic i_startup_done,
  input wire logic i_switch_off_req,
  output logic o_active_hold,
  output logic o_switch_off,
  input wire logic i_watchdog_enable,
  input wire logic i_in_sleep,
  output logic o_watchdog_run,
  input wire logic i_power_off_pin,
  input wire logic i_thermal_trip,
  output pmc_pkg::pmc_shutdown_s o_shutdown,
  input wire logic i_irq_pending,
  input wire logic i_fsd_pending,
  output logic o_irq_pin_out,
  output logic o_irq_pin_oe,
  output logic o_irq_pullup_en,
  input wire logic i_converter_sync_clock,
  input wire logic i_gated_slow_clock,
  output logic o_sync_clock_out
);

  // ---------------------------------------------------------------
  // configuration fields and stay-on bit
  // ---------------------------------------------------------------
  pmc_pkg::pmc_cfg_s cfg_ff;
  pmc_pkg::pmc_cfg_s nxt_cfg;
  logic stay_on_ff;
  logic nxt_stay_on;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_stay_on = stay_on_ff;
    // unknown selects fall to default and change nothing
    if (i_cfg_wr) begin
      case (i_cfg_sel)
        pmc_pkg::FLD_HOST_IF: nxt_cfg.host_if_spi = i_cfg_val[0];
        pmc_pkg::FLD_PAGE_ADDR: nxt_cfg.page_address_select = i_cfg_val[0];
        pmc_pkg::FLD_AUTO_STAY_ON: nxt_cfg.auto_stay_on_enable = i_cfg_val[0];
        pmc_pkg::FLD_OFF_DELAY: nxt_cfg.switch_off_delay = i_cfg_val;
        pmc_pkg::FLD_IRQ_BUF: nxt_cfg.irq_buffer_select = i_cfg_val[0];
        pmc_pkg::FLD_WDT_HOLD: nxt_cfg.watchdog_sleep_hold = i_cfg_val[0];
        pmc_pkg::FLD_PIN_FAST_OFF: nxt_cfg.power_off_pin_fast_off = i_cfg_val[0];
        pmc_pkg::FLD_THERM_FAST_OFF: nxt_cfg.thermal_trip_fast_off = i_cfg_val[0];
        pmc_pkg::FLD_EVT_MASK: nxt_cfg.secondary_event_mask = i_cfg_val[0];
        pmc_pkg::FLD_IRQ_POL: nxt_cfg.irq_polarity_high = i_cfg_val[0];
        pmc_pkg::FLD_SYNC_SEL: nxt_cfg.sync_clock_output_select = i_cfg_val[0];
        pmc_pkg::FLD_STAY_ON: nxt_stay_on = i_cfg_val[0];
        default: nxt_cfg = cfg_ff;
      endcase
    end
    // hardware set beats a host clear in the same cycle
    if (cfg_ff.auto_stay_on_enable && i_startup_done) begin
      nxt_stay_on = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_ff <= pmc_pkg::CFG_RESET;
      stay_on_ff <= pmc_pkg::STAY_ON_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
      stay_on_ff <= nxt_stay_on;
    end
  end

  assign o_cfg = cfg_ff;
  assign o_stay_on = stay_on_ff;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] evt_sync;
  logic [1:0] clk_sync;

  pmc_sync2 #(
    .W(2)
  ) u_evt_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_power_off_pin, i_thermal_trip}),
    .o_sync(evt_sync)
  );

  // the sync clock sources are sampled, so only slow sources pass cleanly
  pmc_sync2 #(
    .W(2)
  ) u_clk_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_converter_sync_clock, i_gated_slow_clock}),
    .o_sync(clk_sync)
  );

  logic pin_off_s;
  logic therm_s;
  logic conv_clk_s;
  logic slow_clk_s;

  assign pin_off_s = evt_sync[1];
  assign therm_s = evt_sync[0];
  assign conv_clk_s = clk_sync[1];
  assign slow_clk_s = clk_sync[0];

  // ---------------------------------------------------------------
  // millisecond tick for the switch-off delay
  // ---------------------------------------------------------------
  logic [pmc_pkg::TICK_W-1:0] tick_cnt_ff;
  logic [pmc_pkg::TICK_W-1:0] nxt_tick_cnt;
  logic tick;
  logic swoff_start;
  logic swoff_busy;
  logic swoff_done;

  assign swoff_start = i_switch_off_req && !swoff_busy;
  assign tick = (tick_cnt_ff == pmc_pkg::TICK_W'(P_TICK_CYCLES - 1));

  // restarting on each request that starts the idle timer keeps the first tick a full period long
  always_comb begin
    if (swoff_start || tick) begin
      nxt_tick_cnt = '0;
    end else begin
      nxt_tick_cnt = tick_cnt_ff + pmc_pkg::TICK_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // delay code is taken at the request edge; later writes do not stretch it
  pmc_swoff_timer u_swoff (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_start(swoff_start),
    .i_delay_sel(cfg_ff.switch_off_delay),
    .o_busy(swoff_busy),
    .o_done(swoff_done)
  );

  // ---------------------------------------------------------------
  // shutdown event routing
  // ---------------------------------------------------------------
  logic pin_off_prev_ff;
  logic therm_prev_ff;
  logic pin_evt;
  logic therm_evt;
  pmc_pkg::pmc_shutdown_s shut_ff;
  pmc_pkg::pmc_shutdown_s nxt_shut;

  function automatic logic rose_edge(input logic now_lvl, input logic last_lvl);
    return now_lvl && !last_lvl;
  endfunction

  assign pin_evt = rose_edge(pin_off_s, pin_off_prev_ff);
  assign therm_evt = rose_edge(therm_s, therm_prev_ff);

  always_comb begin
    nxt_shut = '0;
    if (pin_evt) begin
      if (cfg_ff.power_off_pin_fast_off) begin
        nxt_shut.fast_off = 1'b1;
      end else begin
        nxt_shut.seq_shutdown = 1'b1;
      end
    end
    if (therm_evt) begin
      if (cfg_ff.thermal_trip_fast_off) begin
        nxt_shut.fast_off = 1'b1;
      end else begin
        nxt_shut.seq_shutdown = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_off_prev_ff <= 1'b0;
      therm_prev_ff <= 1'b0;
      shut_ff <= '0;
    end else begin
      pin_off_prev_ff <= pin_off_s;
      therm_prev_ff <= therm_s;
      shut_ff <= nxt_shut;
    end
  end

  assign o_shutdown = shut_ff;

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic host_if_spi_ff;
  logic nxt_host_if_spi;
  logic [6:0] page_addr_ff;
  logic [6:0] nxt_page_addr;
  logic wdt_run_ff;
  logic nxt_wdt_run;
  logic active_hold_ff;
  logic nxt_active_hold;
  logic switch_off_ff;
  logic nxt_switch_off;
  logic irq_out_ff;
  logic nxt_irq_out;
  logic irq_oe_ff;
  logic nxt_irq_oe;
  logic irq_pu_ff;
  logic nxt_irq_pu;
  logic sync_out_ff;
  logic nxt_sync_out;
  logic irq_active;

  always_comb begin
    nxt_host_if_spi = cfg_ff.host_if_spi;
    if (cfg_ff.page_address_select) begin
      nxt_page_addr = pmc_pkg::PAGE_ADDR_ALT;
    end else begin
      nxt_page_addr = pmc_pkg::PAGE_ADDR_DEFAULT;
    end
    nxt_wdt_run = i_watchdog_enable && !(i_in_sleep && cfg_ff.watchdog_sleep_hold);
    // held in ACTIVE from the request until the delay expires
    nxt_active_hold = (swoff_start || swoff_busy) && !swoff_done;
    nxt_switch_off = swoff_done;
    irq_active = i_irq_pending || (i_fsd_pending && !cfg_ff.secondary_event_mask);
    nxt_irq_out = cfg_ff.irq_polarity_high ? irq_active : !irq_active;
    // high-impedance mode releases the line to the internal pullup
    nxt_irq_oe = !cfg_ff.irq_buffer_select;
    nxt_irq_pu = cfg_ff.irq_buffer_select;
    if (cfg_ff.sync_clock_output_select) begin
      nxt_sync_out = slow_clk_s;
    end else begin
      nxt_sync_out = conv_clk_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      host_if_spi_ff <= 1'b0;
      page_addr_ff <= pmc_pkg::PAGE_ADDR_DEFAULT;
      wdt_run_ff <= 1'b0;
      active_hold_ff <= 1'b0;
      switch_off_ff <= 1'b0;
      // line released and inactive while reset holds
      irq_out_ff <= 1'b1;
      irq_oe_ff <= 1'b0;
      irq_pu_ff <= 1'b0;
      sync_out_ff <= 1'b0;
    end else begin
      host_if_spi_ff <= nxt_host_if_spi;
      page_addr_ff <= nxt_page_addr;
      wdt_run_ff <= nxt_wdt_run;
      active_hold_ff <= nxt_active_hold;
      switch_off_ff <= nxt_switch_off;
      irq_out_ff <= nxt_irq_out;
      irq_oe_ff <= nxt_irq_oe;
      irq_pu_ff <= nxt_irq_pu;
      sync_out_ff <= nxt_sync_out;
    end
  end

  assign o_host_if_spi = host_if_spi_ff;
  assign o_page_addr = page_addr_ff;
  assign o_watchdog_run = wdt_run_ff;
  assign o_active_hold = active_hold_ff;
  assign o_switch_off = switch_off_ff;
  assign o_irq_pin_out = irq_out_ff;
  assign o_irq_pin_oe = irq_oe_ff;
  assign o_irq_pullup_en = irq_pu_ff;
  assign o_sync_clock_out = sync_out_ff;

endmodule

// file: logic/pmc_swoff_timer.sv
// switch-off delay timer counting divider ticks
`timescale 1ns/1ns
module pmc_swoff_timer (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [1:0] i_delay_sel,
  output logic o_busy,
  output logic o_done
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_FIRE = 2'b10
  } pmc_tmr_e;

  pmc_tmr_e state_ff;
  pmc_tmr_e nxt_state;
  logic [pmc_pkg::DLY_W-1:0] left_ff;
  logic [pmc_pkg::DLY_W-1:0] nxt_left;

  always_comb begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_start) begin
          nxt_left = pmc_pkg::swoff_delay_ticks(i_delay_sel);
          if (i_delay_sel == pmc_pkg::SWOFF_NONE) begin
            nxt_state = ST_FIRE;
          end else begin
            nxt_state = ST_COUNT;
          end
        end
      end
      ST_COUNT: begin
        if (i_tick) begin
          nxt_left = left_ff - pmc_pkg::DLY_W'(1);
          if (left_ff == pmc_pkg::DLY_W'(1)) begin
            nxt_state = ST_FIRE;
          end
        end
      end
      ST_FIRE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
      left_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
    end
  end

  assign o_busy = (state_ff != ST_IDLE);
  assign o_done = (state_ff == ST_FIRE);

endmodule

// file: logic/pmc_sync2.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module pmc_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

// file: tb/pmc_bank_sva.sv
// port-level assertions for the misc configuration bank
`timescale 1ns/1ns
module pmc_bank_sva (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire pmc_pkg::pmc_cfg_s o_cfg,
  input wire logic o_stay_on,
  input wire logic o_host_if_spi,
  input wire logic [6:0] o_page_addr,
  input wire logic i_startup_done,
  input wire logic i_switch_off_req,
  input wire logic o_active_hold,
  input wire logic o_switch_off,
  input wire logic i_watchdog_enable,
  input wire logic i_in_sleep,
  input wire logic o_watchdog_run,
  input wire logic i_power_off_pin,
  input wire logic i_thermal_trip,
  input wire pmc_pkg::pmc_shutdown_s o_shutdown,
  input wire logic i_irq_pending,
  input wire logic i_fsd_pending,
  input wire logic o_irq_pin_out,
  input wire logic o_irq_pin_oe,
  input wire logic o_irq_pullup_en
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic irq_act;
  logic irq_exp;
  logic wd_exp;
  assign irq_act = i_irq_pending | (i_fsd_pending & !o_cfg.secondary_event_mask);
  assign irq_exp = o_cfg.irq_polarity_high ^ !irq_act;
  assign wd_exp = i_watchdog_enable & !(i_in_sleep & o_cfg.watchdog_sleep_hold);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_host_if_sel: assert property (!$past(i_reset) |->
    o_host_if_spi == $past(o_cfg.host_if_spi)) else $error("host interface select wrong");
  a_page_addr: assert property (!$past(i_reset) |-> o_page_addr ==
    ($past(o_cfg.page_address_select) ? pmc_pkg::PAGE_ADDR_ALT : pmc_pkg::PAGE_ADDR_DEFAULT))
    else $error("page address wrong");
  a_auto_stay_on: assert property (o_cfg.auto_stay_on_enable && i_startup_done |=>
    o_stay_on) else $error("stay-on not set after startup");
  a_swoff_none: assert property (i_switch_off_req && !o_active_hold && !o_switch_off &&
    o_cfg.switch_off_delay == pmc_pkg::SWOFF_NONE |=> o_active_hold ##1
    (o_switch_off && !o_active_hold)) else $error("undelayed switch-off timing wrong");
  a_swoff_held: assert property ($rose(o_switch_off) |-> $past(o_active_hold))
    else $error("switch-off without active hold");
  a_wdog_run: assert property (!$past(i_reset) |-> o_watchdog_run == $past(wd_exp))
    else $error("watchdog run wrong");
  a_pin_seq_off: assert property ($rose(i_power_off_pin) && !i_thermal_trip &&
    !o_cfg.power_off_pin_fast_off |-> ##[2:5] (o_shutdown.seq_shutdown && !o_shutdown.fast_off))
    else $error("pin event not sequenced");
  a_therm_seq_off: assert property ($rose(i_thermal_trip) && !i_power_off_pin &&
    !o_cfg.thermal_trip_fast_off |-> ##[2:5] (o_shutdown.seq_shutdown && !o_shutdown.fast_off))
    else $error("thermal event not sequenced");
  a_fsd_masked: assert property (!$past(i_reset) && $past(o_cfg.secondary_event_mask) &&
    !$past(i_irq_pending) |-> o_irq_pin_out == !$past(o_cfg.irq_polarity_high))
    else $error("masked source reached line");
  a_irq_level: assert property (!$past(i_reset) |-> o_irq_pin_out == $past(irq_exp))
    else $error("interrupt line level wrong");
  a_irq_buffer: assert property (!$past(i_reset) |->
    o_irq_pin_oe != $past(o_cfg.irq_buffer_select) &&
    o_irq_pullup_en == $past(o_cfg.irq_buffer_select)) else $error("buffer mode wrong");
endmodule

// file: tb/pmc_host_model.sv
// host side model issuing configuration writes
`timescale 1ns/1ns
module pmc_host_model (
  input wire logic i_clk,
  output logic o_cfg_wr,
  output pmc_pkg::pmc_field_e o_cfg_sel,
  output logic [1:0] o_cfg_val
);
  initial begin
    o_cfg_wr = 1'h0;
    o_cfg_sel = pmc_pkg::FLD_STAY_ON;
    o_cfg_val = 2'h0;
  end
  // one-cycle strobe; data stops showing the old value once released
  task automatic put(input pmc_pkg::pmc_field_e sel, input logic [1:0] val);
    @(negedge i_clk);
    o_cfg_wr = 1'h1;
    o_cfg_sel = sel;
    o_cfg_val = val;
    @(negedge i_clk);
    o_cfg_wr = 1'h0;
    o_cfg_val = ~val;
  endtask
endmodule

// file: tb/pmc_misc_config_bank_tb_top.sv
// self-checking bench for the misc configuration bank
`timescale 1ns/1ns
module pmc_misc_config_bank_tb_top;
  localparam int TCK = 4;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic i_cfg_wr;
  pmc_pkg::pmc_field_e i_cfg_sel;
  logic [1:0] i_cfg_val;
  pmc_pkg::pmc_cfg_s o_cfg;
  pmc_pkg::pmc_shutdown_s o_shutdown;
  logic o_stay_on, o_host_if_spi, o_active_hold, o_switch_off, o_watchdog_run;
  logic o_irq_pin_out, o_irq_pin_oe, o_irq_pullup_en, o_sync_clock_out;
  logic [6:0] o_page_addr;
  logic i_startup_done = 1'h0, i_switch_off_req = 1'h0, i_watchdog_enable = 1'h0;
  logic i_in_sleep = 1'h0, i_power_off_pin = 1'h0, i_thermal_trip = 1'h0;
  logic i_irq_pending = 1'h0, i_fsd_pending = 1'h0;
  logic i_converter_sync_clock = 1'h0, i_gated_slow_clock = 1'h0;
  int fails = 0;
  int comparisons = 0;
  int n;
  int ms [4] = '{0, pmc_pkg::SWOFF_SHORT_MS, pmc_pkg::SWOFF_MID_MS, pmc_pkg::SWOFF_LONG_MS};
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  pmc_host_model u_host (.i_clk, .o_cfg_wr(i_cfg_wr), .o_cfg_sel(i_cfg_sel),
    .o_cfg_val(i_cfg_val));
  pmc_misc_config_bank #(.P_TICK_CYCLES(TCK)) dut (.i_clk, .i_reset, .i_cfg_wr, .i_cfg_sel,
    .i_cfg_val, .o_cfg, .o_stay_on, .o_host_if_spi, .o_page_addr, .i_startup_done,
    .i_switch_off_req, .o_active_hold, .o_switch_off, .i_watchdog_enable, .i_in_sleep,
    .o_watchdog_run, .i_power_off_pin, .i_thermal_trip, .o_shutdown, .i_irq_pending,
    .i_fsd_pending, .o_irq_pin_out, .o_irq_pin_oe, .o_irq_pullup_en, .i_converter_sync_clock,
    .i_gated_slow_clock, .o_sync_clock_out);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout;
    fails++;
    $display("unexpected at %0t: wait bound used up", $time);
    final_report();
  endtask
  // derived outputs settle one edge after the register update
  task automatic wr(input pmc_pkg::pmc_field_e s, input logic [1:0] v);
    u_host.put(s, v);
    repeat (2) @(negedge i_clk);
  endtask
  task automatic evt(input logic th, input logic [1:0] e);
    int k;
    k = 0;
    i_thermal_trip = th;
    i_power_off_pin = !th;
    while (o_shutdown === 2'h0 && k < 8) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 8) timeout();
    chk(o_shutdown, e);
    i_thermal_trip = 1'h0;
    i_power_off_pin = 1'h0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic off(input int lo, input int hi);
    int k;
    i_switch_off_req = 1'h1;
    @(negedge i_clk);
    i_switch_off_req = 1'h0;
    k = 1;
    chk(o_active_hold, 1'h1);
    while (o_switch_off !== 1'h1 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 2000) timeout();
    chk(k >= lo && k <= hi, 1'h1);
    chk(o_active_hold, 1'h0);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge i_clk);
    chk(o_cfg, pmc_pkg::CFG_RESET);
    chk(o_page_addr, 7'h12);
    chk({o_stay_on, o_irq_pin_oe, o_irq_pullup_en}, 3'h0);
    i_reset = 1'h0;
    i_irq_pending = 1'h1;
    repeat (3) @(negedge i_clk);
    chk({o_host_if_spi, o_irq_pin_out, o_irq_pin_oe}, 3'h1);
    $display("test defaults done");
    wr(pmc_pkg::FLD_HOST_IF, 2'h1);
    chk(o_host_if_spi, 1'h1);
    wr(pmc_pkg::FLD_PAGE_ADDR, 2'h1);
    chk(o_page_addr, pmc_pkg::PAGE_ADDR_ALT);
    wr(pmc_pkg::FLD_PAGE_ADDR, 2'h0);
    wr(pmc_pkg::pmc_field_e'(4'hC), 2'h1);
    chk(o_page_addr, 7'h12);
    chk(o_cfg, 12'h804);
    $display("test interface done");
    i_irq_pending = 1'h0;
    i_fsd_pending = 1'h1;
    repeat (2) @(negedge i_clk);
    chk(o_irq_pin_out, 1'h1);
    wr(pmc_pkg::FLD_EVT_MASK, 2'h0);
    chk(o_irq_pin_out, 1'h0);
    wr(pmc_pkg::FLD_IRQ_POL, 2'h1);
    chk(o_irq_pin_out, 1'h1);
    wr(pmc_pkg::FLD_IRQ_BUF, 2'h1);
    chk({o_irq_pin_oe, o_irq_pullup_en}, 2'h1);
    $display("test interrupt done");
    i_watchdog_enable = 1'h1;
    i_in_sleep = 1'h1;
    repeat (2) @(negedge i_clk);
    chk(o_watchdog_run, 1'h1);
    wr(pmc_pkg::FLD_WDT_HOLD, 2'h1);
    chk(o_watchdog_run, 1'h0);
    $display("test watchdog done");
    evt(1'h0, 2'h1);
    wr(pmc_pkg::FLD_PIN_FAST_OFF, 2'h1);
    evt(1'h0, 2'h2);
    evt(1'h1, 2'h1);
    wr(pmc_pkg::FLD_THERM_FAST_OFF, 2'h1);
    evt(1'h1, 2'h2);
    $display("test shutdown done");
    for (int c = 0; c < 4; c++) begin
      wr(pmc_pkg::FLD_OFF_DELAY, c[1:0]);
      n = ms[c] * TCK;
      off(n, n + 3);
    end
    $display("test switch_off done");
    for (int a = 0; a < 2; a++) begin
      wr(pmc_pkg::FLD_AUTO_STAY_ON, a[1:0]);
      i_startup_done = 1'h1;
      @(negedge i_clk);
      i_startup_done = 1'h0;
      @(negedge i_clk);
      chk(o_stay_on, a[0]);
    end
    $display("test stay_on done");
    i_converter_sync_clock = 1'h1;
    for (int s = 0; s < 2; s++) begin
      wr(pmc_pkg::FLD_SYNC_SEL, s[1:0]);
      repeat (4) @(negedge i_clk);
      chk(o_sync_clock_out, !s[0]);
    end
    chk(o_cfg, 12'hBFB);
    $display("test sync_clock done");
    final_report();
  end
endmodule
bind pmc_misc_config_bank pmc_bank_sva u_sva (.i_clk, .i_reset, .o_cfg, .o_stay_on,
  .o_host_if_spi, .o_page_addr, .i_startup_done, .i_switch_off_req, .o_active_hold,
  .o_switch_off, .i_watchdog_enable, .i_in_sleep, .o_watchdog_run, .i_power_off_pin,
  .i_thermal_trip, .o_shutdown, .i_irq_pending, .i_fsd_pending, .o_irq_pin_out,
  .o_irq_pin_oe, .o_irq_pullup_en);
